// >>> rtl/dmaf_regs.vh
`ifndef DMAF_REGS_VH
`define DMAF_REGS_VH

// ----------------------------------------------------------------
// Register addresses on the special-function-register bus
// ----------------------------------------------------------------
`define DMAF_ADDR_MIDPOINT_FLAGS   8'h88
`define DMAF_ADDR_CHANNEL_ACTIVITY 8'h91
`define DMAF_ADDR_CHANNEL_ENABLES  8'h92
`define DMAF_ADDR_COMPLETION_FLAGS 8'hE8

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define DMAF_NUM_CH     7
`define DMAF_CH_MSB     6
`define DMAF_UNUSED_BIT 7
`define DMAF_OFS_W      10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMAF_RST_ENABLES  7'h00
`define DMAF_RST_FLAGS    7'h00
`define DMAF_RST_ACTIVITY 7'h00
`define DMAF_RST_OFS      10'h000
`define DMAF_RST_RDATA    8'h00

// ----------------------------------------------------------------
// Counter arithmetic
// ----------------------------------------------------------------
`define DMAF_OFS_ONE 10'h001

`endif

// >>> rtl/dmaf_channel.v
`include "dmaf_regs.vh"

module dmaf_channel (
  input  wire        clk_in,        // Core clock
  input  wire        rst_in,        // Async reset, high
  input  wire        ce_in,         // Clock enable
  input  wire        enable_in,     // Channel enable bit
  input  wire        periph_req_in, // Peripheral transfer request
  input  wire        force_in,      // Software forced start pulse
  input  wire        byte_done_in,  // One byte moved pulse
  input  wire        ofs_wr_in,     // Counter write strobe
  input  wire [9:0]  ofs_wdata_in,  // Counter write value
  input  wire [9:0]  size_in,       // Transfer size
  input  wire        cf_wr_in,      // Completion flag write
  input  wire        cf_wdata_in,   // Completion flag value
  input  wire        mf_wr_in,      // Midpoint flag write
  input  wire        mf_wdata_in,   // Midpoint flag value
  output wire        busy_out,      // Activity bit
  output wire        cf_out,        // Completion flag
  output wire        mf_out,        // Midpoint flag
  output wire [9:0]  ofs_out        // Byte offset counter
);

  reg        busy_q;
  reg        busy_d;
  reg        cf_q;
  reg        cf_d;
  reg        mf_q;
  reg        mf_d;
  reg  [9:0] ofs_q;
  reg  [9:0] ofs_d;
  wire [9:0] ofs_inc;
  wire [9:0] full_tgt;
  wire [9:0] mid_tgt;
  wire       blocked;

  // ----------------------------------------------------------------
  // Targets and increment
  // ----------------------------------------------------------------
  assign ofs_inc  = ofs_q + `DMAF_OFS_ONE;
  assign full_tgt = size_in - `DMAF_OFS_ONE;
  assign mid_tgt  = {1'b0, size_in[9:1]} + {9'h000, size_in[0]};
  assign blocked  = cf_q | mf_q;

  // Next state of counter, flags and activity
  always @* begin
    ofs_d  = ofs_q;
    cf_d   = cf_q;
    mf_d   = mf_q;
    busy_d = busy_q;
    if (ofs_wr_in && !busy_q) begin
      ofs_d = ofs_wdata_in;
    end else if (byte_done_in && busy_q) begin
      ofs_d = ofs_inc;
    end
    if (cf_wr_in) begin
      cf_d = cf_wdata_in;
    end
    if (mf_wr_in) begin
      mf_d = mf_wdata_in;
    end
    if (byte_done_in && busy_q && ofs_inc == full_tgt) begin
      cf_d = 1'b1;
    end
    if (byte_done_in && busy_q && ofs_inc == mid_tgt) begin
      mf_d = 1'b1;
    end
    if (byte_done_in && busy_q) begin
      busy_d = 1'b0;
    end else if (enable_in && !blocked && (periph_req_in || force_in)) begin
      busy_d = 1'b1;
    end
  end

  // State registers
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ofs_q  <= `DMAF_RST_OFS;
      cf_q   <= 1'b0;
      mf_q   <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce_in) begin
      ofs_q  <= ofs_d;
      cf_q   <= cf_d;
      mf_q   <= mf_d;
      busy_q <= busy_d;
    end
  end

  assign busy_out = busy_q;
  assign cf_out   = cf_q;
  assign mf_out   = mf_q;
  assign ofs_out  = ofs_q;

endmodule

// >>> rtl/dmaf_top.v
`include "dmaf_regs.vh"

module dmaf_top (
  input  wire        clk_in,          // Core clock, 100 MHz
  input  wire        rst_in,          // Async reset, high
  input  wire        ce_in,           // Clock enable, freezes state
  input  wire [7:0]  sfr_addr_in,     // Register address
  input  wire        sfr_wr_in,       // Register write strobe
  input  wire        sfr_rd_in,       // Register read strobe
  input  wire [7:0]  sfr_wdata_in,    // Register write data
  output wire [7:0]  sfr_rdata_out,   // Register read data
  input  wire [2:0]  channel_selector_in,   // Selected channel
  input  wire        ofs_wr_in,       // Offset write, selected channel
  input  wire [9:0]  ofs_wdata_in,    // Offset write value
  output wire [9:0]  ofs_rdata_out,   // Offset of selected channel
  input  wire [69:0] transfer_size_in, // Sizes, 10 bits per channel
  input  wire [6:0]  completion_irq_enable_in, // Full length enables
  input  wire [6:0]  midpoint_irq_enable_in,   // Midpoint enables
  input  wire [6:0]  periph_req_in,   // Peripheral requests
  input  wire [6:0]  byte_done_in,    // Byte moved pulses
  output wire [6:0]  channel_run_out, // Channels running
  output wire [6:0]  completion_irq_out, // Gated full length requests
  output wire [6:0]  midpoint_irq_out,   // Gated midpoint requests
  output wire        dma_irq_out      // Combined interrupt request
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [6:0]  enables_q;
  reg  [6:0]  enables_d;
  reg  [7:0]  rdata_q;
  reg  [7:0]  rdata_d;
  reg  [9:0]  ofs_rd_q;
  reg  [9:0]  ofs_rd_d;
  reg         wr_en;
  reg         wr_cf;
  reg         wr_mf;
  reg         wr_act;
  wire [6:0]  activity;
  wire [6:0]  completion_flag;
  wire [6:0]  midpoint_flag;
  wire [69:0] ofs_all;
  wire [6:0]  force_start;
  wire [6:0]  comp_gated;
  wire [6:0]  mid_gated;

  // ----------------------------------------------------------------
  // Write address decode
  // ----------------------------------------------------------------

  // Register write strobes
  always @* begin
    wr_en  = 1'b0;
    wr_cf  = 1'b0;
    wr_mf  = 1'b0;
    wr_act = 1'b0;
    if (sfr_wr_in && sfr_addr_in == `DMAF_ADDR_CHANNEL_ENABLES) begin
      wr_en = 1'b1;
    end else if (sfr_wr_in &&
                 sfr_addr_in == `DMAF_ADDR_COMPLETION_FLAGS) begin
      wr_cf = 1'b1;
    end else if (sfr_wr_in &&
                 sfr_addr_in == `DMAF_ADDR_MIDPOINT_FLAGS) begin
      wr_mf = 1'b1;
    end else if (sfr_wr_in &&
                 sfr_addr_in == `DMAF_ADDR_CHANNEL_ACTIVITY) begin
      wr_act = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Channel enable register
  // ----------------------------------------------------------------

  // Next enable value
  always @* begin
    enables_d = enables_q;
    if (wr_en) begin
      enables_d = sfr_wdata_in[`DMAF_CH_MSB:0];
    end
  end

  // Enable register
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enables_q <= `DMAF_RST_ENABLES;
    end else if (ce_in) begin
      enables_q <= enables_d;
    end
  end

  // ----------------------------------------------------------------
  // Start and counter write steering
  // ----------------------------------------------------------------

  assign force_start = wr_act ? sfr_wdata_in[`DMAF_CH_MSB:0] :
                                `DMAF_RST_ACTIVITY;

  // ----------------------------------------------------------------
  // Per channel flag and activity logic
  // ----------------------------------------------------------------
  // One instance per channel, counter writes steered by the selector
  dmaf_channel u_chan0 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[0]),
    .periph_req_in (periph_req_in[0]),
    .force_in      (force_start[0]),
    .byte_done_in  (byte_done_in[0]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h0),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[9:0]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[0]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[0]),
    .busy_out      (activity[0]),
    .cf_out        (completion_flag[0]),
    .mf_out        (midpoint_flag[0]),
    .ofs_out       (ofs_all[9:0])
  );
  dmaf_channel u_chan1 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[1]),
    .periph_req_in (periph_req_in[1]),
    .force_in      (force_start[1]),
    .byte_done_in  (byte_done_in[1]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h1),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[19:10]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[1]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[1]),
    .busy_out      (activity[1]),
    .cf_out        (completion_flag[1]),
    .mf_out        (midpoint_flag[1]),
    .ofs_out       (ofs_all[19:10])
  );
  dmaf_channel u_chan2 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[2]),
    .periph_req_in (periph_req_in[2]),
    .force_in      (force_start[2]),
    .byte_done_in  (byte_done_in[2]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h2),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[29:20]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[2]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[2]),
    .busy_out      (activity[2]),
    .cf_out        (completion_flag[2]),
    .mf_out        (midpoint_flag[2]),
    .ofs_out       (ofs_all[29:20])
  );
  dmaf_channel u_chan3 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[3]),
    .periph_req_in (periph_req_in[3]),
    .force_in      (force_start[3]),
    .byte_done_in  (byte_done_in[3]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h3),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[39:30]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[3]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[3]),
    .busy_out      (activity[3]),
    .cf_out        (completion_flag[3]),
    .mf_out        (midpoint_flag[3]),
    .ofs_out       (ofs_all[39:30])
  );
  dmaf_channel u_chan4 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[4]),
    .periph_req_in (periph_req_in[4]),
    .force_in      (force_start[4]),
    .byte_done_in  (byte_done_in[4]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h4),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[49:40]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[4]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[4]),
    .busy_out      (activity[4]),
    .cf_out        (completion_flag[4]),
    .mf_out        (midpoint_flag[4]),
    .ofs_out       (ofs_all[49:40])
  );
  dmaf_channel u_chan5 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[5]),
    .periph_req_in (periph_req_in[5]),
    .force_in      (force_start[5]),
    .byte_done_in  (byte_done_in[5]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h5),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[59:50]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[5]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[5]),
    .busy_out      (activity[5]),
    .cf_out        (completion_flag[5]),
    .mf_out        (midpoint_flag[5]),
    .ofs_out       (ofs_all[59:50])
  );
  dmaf_channel u_chan6 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .enable_in     (enables_q[6]),
    .periph_req_in (periph_req_in[6]),
    .force_in      (force_start[6]),
    .byte_done_in  (byte_done_in[6]),
    .ofs_wr_in     (ofs_wr_in && channel_selector_in == 3'h6),
    .ofs_wdata_in  (ofs_wdata_in),
    .size_in       (transfer_size_in[69:60]),
    .cf_wr_in      (wr_cf),
    .cf_wdata_in   (sfr_wdata_in[6]),
    .mf_wr_in      (wr_mf),
    .mf_wdata_in   (sfr_wdata_in[6]),
    .busy_out      (activity[6]),
    .cf_out        (completion_flag[6]),
    .mf_out        (midpoint_flag[6]),
    .ofs_out       (ofs_all[69:60])
  );

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------

  assign comp_gated = completion_flag & completion_irq_enable_in;
  assign mid_gated  = midpoint_flag & midpoint_irq_enable_in;
  assign dma_irq_out = |(comp_gated | mid_gated);

  assign completion_irq_out = comp_gated;
  assign midpoint_irq_out   = mid_gated;
  assign channel_run_out    = activity;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Read multiplexer, registered on the read strobe
  always @* begin
    rdata_d = rdata_q;
    if (sfr_rd_in) begin
      rdata_d = `DMAF_RST_RDATA;
      if (sfr_addr_in == `DMAF_ADDR_CHANNEL_ENABLES) begin
        rdata_d = {1'b0, enables_q};
      end else if (sfr_addr_in == `DMAF_ADDR_COMPLETION_FLAGS) begin
        rdata_d = {1'b0, completion_flag};
      end else if (sfr_addr_in == `DMAF_ADDR_MIDPOINT_FLAGS) begin
        rdata_d = {1'b0, midpoint_flag};
      end else if (sfr_addr_in == `DMAF_ADDR_CHANNEL_ACTIVITY) begin
        rdata_d = {1'b0, activity};
      end
    end
  end

  // Offset of the selected channel, reserved code reads zero
  always @* begin
    ofs_rd_d = `DMAF_RST_OFS;
    case (channel_selector_in)
      3'h0: ofs_rd_d = ofs_all[9:0];
      3'h1: ofs_rd_d = ofs_all[19:10];
      3'h2: ofs_rd_d = ofs_all[29:20];
      3'h3: ofs_rd_d = ofs_all[39:30];
      3'h4: ofs_rd_d = ofs_all[49:40];
      3'h5: ofs_rd_d = ofs_all[59:50];
      3'h6: ofs_rd_d = ofs_all[69:60];
      default: ofs_rd_d = `DMAF_RST_OFS;
    endcase
  end

  // Read data registers
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q  <= `DMAF_RST_RDATA;
      ofs_rd_q <= `DMAF_RST_OFS;
    end else if (ce_in) begin
      rdata_q  <= rdata_d;
      ofs_rd_q <= ofs_rd_d;
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign ofs_rdata_out = ofs_rd_q;

endmodule

// >>> tb/dmaf_far_model.sv
module dmaf_far_model (
  input  wire logic       clk_in,  // Core clock
  input  wire logic       slow_in, // Add wait states
  input  wire logic [6:0] run_in,  // Channels running
  output wire logic [6:0] done_out // Byte moved pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;

  // ------------------------------------------------
  // Byte mover
  // ------------------------------------------------
  // Wait cycles counted while any channel runs
  always @(posedge clk_in) begin
    wait_q <= (|run_in) ? wait_q + 2'h1 : 2'h0;
  end
  // One byte per run, late when slow
  assign done_out = (slow_in && wait_q != 2'h3) ? 7'h00 : run_in;
endmodule

// >>> tb/dmaf_top_chk.sv
module dmaf_top_chk (
  input wire logic        clk_in,                   // Clock
  input wire logic        rst_in,                   // Reset
  input wire logic        ce_in,                    // Clock enable
  input wire logic [7:0]  sfr_addr_in,              // Address
  input wire logic        sfr_wr_in,                // Write
  input wire logic        sfr_rd_in,                // Read
  input wire logic [7:0]  sfr_wdata_in,             // Write data
  input wire logic [7:0]  sfr_rdata_out,            // Read data
  input wire logic [2:0]  channel_selector_in,      // Selector
  input wire logic        ofs_wr_in,                // Offset write
  input wire logic [9:0]  ofs_wdata_in,             // Offset value
  input wire logic [9:0]  ofs_rdata_out,            // Offset readback
  input wire logic [69:0] transfer_size_in,         // Sizes
  input wire logic [6:0]  completion_irq_enable_in, // Full enables
  input wire logic [6:0]  midpoint_irq_enable_in,   // Mid enables
  input wire logic [6:0]  periph_req_in,            // Requests
  input wire logic [6:0]  byte_done_in,             // Byte pulses
  input wire logic [6:0]  channel_run_out,          // Running
  input wire logic [6:0]  completion_irq_out,       // Full requests
  input wire logic [6:0]  midpoint_irq_out,         // Mid requests
  input wire logic        dma_irq_out               // Combined request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] mid0;
  logic       sel0;
  logic       byte0;

  // Channel 0 midpoint target and byte event
  assign mid0  = (transfer_size_in[9:0] >> 1) + {9'h000, transfer_size_in[0]};
  assign sel0  = channel_selector_in == 3'h0 && !ofs_wr_in;
  assign byte0 = ce_in && byte_done_in[0] && channel_run_out[0] && sel0;

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_irq_combine: assert property (
    dma_irq_out == |(completion_irq_out | midpoint_irq_out))
    else $error("combined request wrong");
  a_irq_gated: assert property (
    ((completion_irq_out & ~completion_irq_enable_in)
     | (midpoint_irq_out & ~midpoint_irq_enable_in)) == 7'h00)
    else $error("request without enable");
  a_rd_top_zero: assert property (
    ce_in && sfr_rd_in |=> !sfr_rdata_out[7]) else $error("read bit 7 set");
  a_run_until_done: assert property (
    ce_in |=> (channel_run_out & $past(channel_run_out))
      == ($past(channel_run_out) & ~$past(byte_done_in)))
    else $error("run bit wrong");
  a_start_blocked: assert property (
    ce_in |=> (channel_run_out & ~$past(channel_run_out)
      & ($past(completion_irq_out) | $past(midpoint_irq_out))) == 7'h00)
    else $error("start while flag set");
  a_ofs_step: assert property (
    byte0 ##1 sel0 |=> ofs_rdata_out == $past(ofs_rdata_out) + 10'h001)
    else $error("offset did not step");
  a_cflag_end: assert property (
    byte0 && completion_irq_enable_in[0] ##1 sel0 ##1
    ofs_rdata_out == transfer_size_in[9:0] - 10'h001 |-> completion_irq_out[0])
    else $error("completion flag missing");
  a_mflag_mid: assert property (
    byte0 && midpoint_irq_enable_in[0] ##1 sel0 ##1
    ofs_rdata_out == mid0 |-> midpoint_irq_out[0])
    else $error("midpoint flag missing");
endmodule

// >>> tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_in, ce_in, sfr_wr_in, sfr_rd_in, ofs_wr_in;
  logic        dma_irq_out, slow;
  logic [2:0]  channel_selector_in;
  logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [9:0]  ofs_wdata_in, ofs_rdata_out;
  logic [69:0] transfer_size_in;
  logic [6:0]  completion_irq_enable_in, midpoint_irq_enable_in;
  logic [6:0]  periph_req_in, byte_done_in, channel_run_out;
  logic [6:0]  completion_irq_out, midpoint_irq_out;
  int          fail_count, cmp_count;

  dmaf_top i_dmaf_top (.*);
  dmaf_far_model i_dmaf_far_model (
    .clk_in  (clk_in),
    .slow_in (slow),
    .run_in  (channel_run_out),
    .done_out(byte_done_in)
  );

  // ------------------------------------------------
  // Bus tasks and checks
  // ------------------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sfr_cycle(input logic wr, input logic [7:0] a, d);
    @(posedge clk_in) #1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = wr;
    sfr_rd_in = !wr;
    @(posedge clk_in) #1;
    sfr_wr_in = 0;
    sfr_rd_in = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_cycle(0, a, 8'h00);
    chk({2'h0, sfr_rdata_out}, {2'h0, exp});
  endtask
  task automatic wait_hi(input int ch, input logic mid);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_in) #1;
      if ((mid ? midpoint_irq_out[ch] : completion_irq_out[ch]) === 1'b1)
        break;
    end
  endtask
  // Full transfer on one channel, software clears each flag
  task automatic run_ch(input int ch, input logic [9:0] sz);
    logic [9:0] mid;
    mid = (sz >> 1) + {9'h000, sz[0]};
    @(posedge clk_in) #1;
    transfer_size_in[ch*10 +: 10] = sz;
    channel_selector_in = ch[2:0];
    ofs_wr_in = 1;
    slow = ch[0];
    @(posedge clk_in) #1;
    ofs_wr_in = 0;
    sfr_cycle(1, 8'h91, 8'h01 << ch);
    periph_req_in[ch] = 1;
    wait_hi(ch, 1);
    rd(8'h88, 8'h01 << ch);
    chk(ofs_rdata_out, mid);
    chk({9'h000, channel_run_out[ch]}, 10'h000);
    chk({3'h0, midpoint_irq_out}, 10'h001 << ch);
    midpoint_irq_enable_in[ch] = 0;
    @(posedge clk_in) #1;
    chk({3'h0, midpoint_irq_out}, 10'h000);
    chk({9'h000, dma_irq_out}, 10'h000);
    midpoint_irq_enable_in[ch] = 1;
    sfr_cycle(1, 8'h88, 8'h00);
    wait_hi(ch, 0);
    periph_req_in[ch] = 0;
    rd(8'hE8, 8'h01 << ch);
    chk(ofs_rdata_out, sz - 10'h001);
    chk({9'h000, dma_irq_out}, 10'h001);
    completion_irq_enable_in[ch] = 0;
    @(posedge clk_in) #1;
    chk({9'h000, dma_irq_out}, 10'h000);
    chk({3'h0, completion_irq_out}, 10'h000);
    completion_irq_enable_in[ch] = 1;
    rd(8'hE8, 8'h01 << ch);
    sfr_cycle(1, 8'hE8, 8'h00);
    chk({9'h000, dma_irq_out}, 10'h000);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    {rst_in, ce_in, sfr_wr_in, sfr_rd_in, ofs_wr_in, slow} = 6'h30;
    {sfr_addr_in, sfr_wdata_in, channel_selector_in} = 19'h00000;
    {ofs_wdata_in, transfer_size_in, periph_req_in} = 87'h0;
    completion_irq_enable_in = 7'h7F;
    midpoint_irq_enable_in = 7'h7F;
    fail_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_in);
    #1 rst_in = 0;
    rd(8'h92, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'hE8, 8'h00);
    rd(8'h91, 8'h00);
    sfr_cycle(1, 8'h91, 8'h01);
    rd(8'h55, 8'h00);
    chk({3'h0, channel_run_out}, 10'h000);
    sfr_cycle(1, 8'h92, 8'hFF);
    rd(8'h92, 8'h7F);
    ce_in = 0;
    sfr_cycle(1, 8'h92, 8'h00);
    ce_in = 1;
    rd(8'h92, 8'h7F);
    for (int ch = 0; ch < 7; ch++)
      run_ch(ch, 10'(ch + 4));
    @(posedge clk_in) #1;
    rst_in = 1;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 0;
    rd(8'h92, 8'h00);
    chk(ofs_rdata_out, 10'h000);
    stop_test();
  end
endmodule

bind dmaf_top dmaf_top_chk i_dmaf_top_chk (.*);
